// [core/fdd_pkg.sv]
// Purpose: Shared constants, pin bundles and state layout for the disk interface
// Assumes: 100 MHz clk; registers are word-aligned Wishbone slots
// Notes:   Register slot n sits at byte address 4*n
package fdd_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Register slot indices
  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_MODE   = 4'h1;
  localparam logic [3:0] IDX_DCTL   = 4'h2;
  localparam logic [3:0] IDX_SEEK   = 4'h3;
  localparam logic [3:0] IDX_MSR    = 4'h4;
  localparam logic [3:0] IDX_RATE   = 4'h5;
  localparam logic [3:0] IDX_OP     = 4'h6;
  localparam logic [3:0] IDX_DIN    = 4'h7;
  localparam logic [3:0] IDX_DATA   = 4'h8;

  // Field positions
  localparam int CFG_ENC_BIT  = 7;
  localparam int MODE_RG_BIT  = 7;
  localparam int DCTL_SEL_BIT = 0;
  localparam int DCTL_DMA_BIT = 3;
  localparam int DCTL_MTR0    = 4;
  localparam int DCTL_MTR1    = 5;
  localparam int OP_HEAD_BIT  = 0;
  localparam int OP_RD_BIT    = 1;
  localparam int OP_WR_BIT    = 2;
  localparam int SEEK_IN_BIT  = 7;
  localparam int DIN_CHG_BIT  = 7;
  localparam int MSR_BUSY_BIT = 4;

  // Values after reset
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] DCTL_RST   = 8'h00;
  localparam logic [1:0] RATE_RST   = 2'h2;
  localparam logic [7:0] MSR_BASE   = 8'h80;

  // Data rate codes
  localparam logic [1:0] RATE_500 = 2'h0;
  localparam logic [1:0] RATE_300 = 2'h1;
  localparam logic [1:0] RATE_250 = 2'h2;
  localparam logic [1:0] RATE_1M  = 2'h3;

  // Times and derived cycle counts
  localparam int STEP_UNIT_NS  = 1000000;
  localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_PERIOD_NS;
  localparam int STEP_PULSE_NS = 1000;
  localparam logic [6:0] STEP_PULSE_CYC = 7'(STEP_PULSE_NS / CLK_PERIOD_NS);
  localparam int WPULSE_NS     = 100;
  localparam logic [8:0] WPULSE_CYC = 9'(WPULSE_NS / CLK_PERIOD_NS);
  localparam logic [8:0] CELL_500_CYC = 9'(2000 / CLK_PERIOD_NS);
  localparam logic [8:0] CELL_300_CYC = 9'(3330 / CLK_PERIOD_NS);
  localparam logic [8:0] CELL_250_CYC = 9'(4000 / CLK_PERIOD_NS);
  localparam logic [8:0] CELL_1M_CYC  = 9'(1000 / CLK_PERIOD_NS);

  // Raw drive-side and host-side inputs; bit 0 is dma_grant_n
  typedef struct packed {
    logic master_clear;
    logic addr_decode_block;
    logic disk_read_n;
    logic track_start_n;
    logic home_track_n;
    logic media_locked_n;
    logic media_change;
    logic transfer_end_in;
    logic dma_grant_n;
  } drv_in_s;

  localparam logic [8:0] IN_RST = 9'h079;

  // Pin outputs; an _oe bit high pulls its open-drain pin low
  typedef struct packed {
    logic       head_travel_oe;
    logic [1:0] unit_select_n_oe;
    logic [1:0] spindle_on_n_oe;
    logic       head_choice_oe;
    logic       disk_write_data_oe;
    logic       disk_write_enable_oe;
    logic       head_move_oe;
    logic       rate_band;
    logic       separator_lock_sel;
    logic       dma_request;
    logic       disk_interrupt;
  } drv_out_s;

  localparam logic [12:0] OUT_RST = 13'h0004;

  typedef struct packed {
    logic [8:0]  sync1;
    logic [8:0]  sync2;
    logic [8:0]  sync3;
    logic [8:0]  filt;
    logic [8:0]  filt_q;
    logic        ack;
    logic [7:0]  rdat;
    logic [7:0]  config_r;
    logic [7:0]  mode;
    logic [7:0]  dctl;
    logic [1:0]  rate;
    logic [2:0]  op;
    logic [7:0]  wbuf;
    logic        wfull;
    logic [7:0]  shift;
    logic [3:0]  bitcnt;
    logic [8:0]  cellcnt;
    logic        seeking;
    logic        dir_in;
    logic [6:0]  steps_left;
    logic [20:0] period_cnt;
    logic [6:0]  pulse_cnt;
    logic        int_pend;
    logic [7:0]  rd_pulses;
    drv_out_s    pins;
  } fdd_state_s;

endpackage

// [core/flexible_disk_drive_interface.sv]
// Purpose: Drive-side pin control of a flexible-disk interface, Wishbone slave
// Assumes: Drive inputs are asynchronous and pass a three-stage filter
// Notes:   How it works
`timescale 1ns/1ps
`default_nettype none
module flexible_disk_drive_interface
  import fdd_pkg::*;
#(
  parameter int STEP_UNIT = STEP_UNIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire drv_in_s     drv_in,
  output drv_out_s         drv_out
);

  fdd_state_s st_ff;
  fdd_state_s nxt_st;

  localparam int B_GRANT = 0;
  localparam int B_TEND  = 1;
  localparam int B_CHG   = 2;
  localparam int B_LOCK  = 3;
  localparam int B_HOME  = 4;
  localparam int B_TRK   = 5;
  localparam int B_RD    = 6;
  localparam int B_BLOCK = 7;
  localparam int B_MC    = 8;

  logic       req;
  logic       wr_commit;
  logic [3:0] idx;
  logic       grant_act;
  logic       locked;
  logic       wr_mode;
  logic       rd_mode;
  logic [8:0] cell_len;
  logic [8:0] pre;
  logic [7:0] msr;
  logic [7:0] din;
  logic       sel1;
  logic       mtr_sel;

  assign wb_dat_o = {24'h000000, st_ff.rdat};
  assign wb_ack_o = st_ff.ack;
  assign drv_out  = st_ff.pins;

  always_comb begin
    nxt_st = st_ff;

    // Input filter: a change counts once stages two and three agree
    nxt_st.sync1  = drv_in;
    nxt_st.sync2  = st_ff.sync1;
    nxt_st.sync3  = st_ff.sync2;
    nxt_st.filt_q = st_ff.filt;
    for (int i = 0; i < 9; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.filt[i] = st_ff.sync3[i];
      end
    end

    idx       = wb_adr_i[5:2];
    req       = wb_cyc_i && wb_stb_i;
    // Writes land at the edge where the master sees ack
    wr_commit = req && wb_we_i && wb_sel_i[0] && st_ff.ack
                && !st_ff.filt[B_BLOCK];
    grant_act = !st_ff.filt[B_GRANT] && st_ff.dctl[DCTL_DMA_BIT];
    locked    = !st_ff.filt[B_LOCK];
    wr_mode   = st_ff.op[OP_WR_BIT] && !locked;
    rd_mode   = st_ff.op[OP_RD_BIT];
    sel1      = st_ff.dctl[DCTL_SEL_BIT];
    mtr_sel   = sel1 ? st_ff.dctl[DCTL_MTR1] : st_ff.dctl[DCTL_MTR0];
    pre       = {6'h00, st_ff.mode[6:4]};

    case (st_ff.rate)
      RATE_500: cell_len = CELL_500_CYC;
      RATE_300: cell_len = CELL_300_CYC;
      RATE_250: cell_len = CELL_250_CYC;
      RATE_1M:  cell_len = CELL_1M_CYC;
      default:  cell_len = CELL_250_CYC;
    endcase

    msr = MSR_BASE;
    msr[MSR_BUSY_BIT] = rd_mode || wr_mode;
    msr[0] = st_ff.seeking && !sel1;
    msr[1] = st_ff.seeking && sel1;

    din = 8'h00;
    din[DIN_CHG_BIT] = st_ff.filt[B_CHG];
    din[0] = !st_ff.filt[B_HOME];
    din[1] = locked;
    din[2] = !st_ff.filt[B_TRK];

    // Bus slave: one ack per request, dropped the cycle after
    nxt_st.ack  = req && !st_ff.ack;
    nxt_st.rdat = 8'h00;
    if (req && !st_ff.ack && !wb_we_i
        && !st_ff.filt[B_BLOCK]) begin
      case (idx)
        IDX_CONFIG: nxt_st.rdat = st_ff.config_r;
        IDX_MODE:   nxt_st.rdat = st_ff.mode;
        IDX_DCTL:   nxt_st.rdat = st_ff.dctl;
        IDX_SEEK:   nxt_st.rdat = {st_ff.dir_in, st_ff.steps_left};
        IDX_MSR:    nxt_st.rdat = msr;
        IDX_RATE:   nxt_st.rdat = {6'h00, st_ff.rate};
        IDX_OP:     nxt_st.rdat = {5'h00, st_ff.op};
        IDX_DIN:    nxt_st.rdat = din;
        IDX_DATA:   nxt_st.rdat = st_ff.rd_pulses;
        default:    nxt_st.rdat = 8'h00;
      endcase
    end

    if (wr_commit) begin
      case (idx)
        IDX_CONFIG: nxt_st.config_r = wb_dat_i[7:0];
        IDX_MODE:   nxt_st.mode = wb_dat_i[7:0];
        IDX_DCTL:   nxt_st.dctl = wb_dat_i[7:0];
        IDX_RATE:   nxt_st.rate = wb_dat_i[1:0];
        IDX_OP: begin
          nxt_st.op = wb_dat_i[2:0];
          if (locked) begin
            nxt_st.op[OP_WR_BIT] = 1'b0;
          end
          if (wb_dat_i[OP_RD_BIT]) begin
            nxt_st.rd_pulses = 8'h00;
          end
        end
        IDX_SEEK: begin
          nxt_st.steps_left = wb_dat_i[6:0];
          nxt_st.dir_in     = wb_dat_i[SEEK_IN_BIT];
          nxt_st.seeking    = 1'b1;
          nxt_st.period_cnt = 21'h000000;
        end
        IDX_DATA: begin
          if (!locked) begin
            nxt_st.wbuf  = wb_dat_i[7:0];
            nxt_st.wfull = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Seek stepping at the programmed rate
    if (st_ff.pulse_cnt != 7'h00) begin
      nxt_st.pulse_cnt = st_ff.pulse_cnt - 7'h01;
    end
    if (st_ff.seeking) begin
      if (!st_ff.dir_in && !st_ff.filt[B_HOME]) begin
        nxt_st.steps_left = 7'h00;
      end
      if (st_ff.period_cnt != 21'h000000) begin
        nxt_st.period_cnt = st_ff.period_cnt - 21'h000001;
      end else if (st_ff.steps_left != 7'h00
                   && (st_ff.dir_in || st_ff.filt[B_HOME])) begin
        nxt_st.steps_left = st_ff.steps_left - 7'h01;
        nxt_st.pulse_cnt  = STEP_PULSE_CYC;
        nxt_st.period_cnt =
          21'((int'(st_ff.mode[3:0]) + 1) * STEP_UNIT - 1);
      end else begin
        nxt_st.seeking  = 1'b0;
        nxt_st.int_pend = 1'b1;
      end
    end

    // Serial write stream, one bit cell per data bit
    if (st_ff.bitcnt != 4'h0) begin
      if (st_ff.cellcnt == cell_len - 9'h001) begin
        nxt_st.cellcnt = 9'h000;
        nxt_st.shift   = {st_ff.shift[6:0], 1'b0};
        nxt_st.bitcnt  = st_ff.bitcnt - 4'h1;
      end else begin
        nxt_st.cellcnt = st_ff.cellcnt + 9'h001;
      end
      if (!wr_mode) begin
        nxt_st.bitcnt = 4'h0;
      end
    end else if (wr_mode && st_ff.wfull) begin
      nxt_st.shift   = st_ff.wbuf;
      nxt_st.bitcnt  = 4'h8;
      nxt_st.cellcnt = 9'h000;
      nxt_st.wfull   = 1'b0;
    end

    // Raw read pulses counted on falling edges
    if (rd_mode && st_ff.filt_q[B_RD] && !st_ff.filt[B_RD]) begin
      nxt_st.rd_pulses = st_ff.rd_pulses + 8'h01;
    end

    // Transfer end ends the operation while the DMA grant is active
    if (st_ff.filt[B_TEND] && grant_act) begin
      nxt_st.op[OP_RD_BIT] = 1'b0;
      nxt_st.op[OP_WR_BIT] = 1'b0;
      nxt_st.wfull         = 1'b0;
      nxt_st.int_pend      = 1'b1;
    end

    // Reading main status clears the pending flag; a new event in that cycle wins only if the flag was clear
    if (req && st_ff.ack && !wb_we_i && idx == IDX_MSR
        && !st_ff.filt[B_BLOCK] && nxt_st.int_pend == st_ff.int_pend) begin
      nxt_st.int_pend = 1'b0;
    end

    // Pin outputs
    nxt_st.pins.head_travel_oe = st_ff.dir_in
                                 && !(rd_mode || wr_mode);
    if (st_ff.config_r[CFG_ENC_BIT]) begin
      nxt_st.pins.unit_select_n_oe = {sel1, !sel1};
      nxt_st.pins.spindle_on_n_oe  = {st_ff.dctl[DCTL_MTR1]
                                      | st_ff.dctl[DCTL_MTR0],
                                      mtr_sel};
    end else begin
      nxt_st.pins.unit_select_n_oe[0] = !sel1 && st_ff.dctl[DCTL_MTR0];
      nxt_st.pins.unit_select_n_oe[1] = sel1 && st_ff.dctl[DCTL_MTR1];
      nxt_st.pins.spindle_on_n_oe = {st_ff.dctl[DCTL_MTR1],
                                     st_ff.dctl[DCTL_MTR0]};
    end
    nxt_st.pins.head_choice_oe = st_ff.op[OP_HEAD_BIT];
    nxt_st.pins.disk_write_data_oe = wr_mode && st_ff.bitcnt != 4'h0
                                     && st_ff.shift[7]
                                     && st_ff.cellcnt >= pre
                                     && st_ff.cellcnt < pre + WPULSE_CYC;
    nxt_st.pins.disk_write_enable_oe = wr_mode;
    nxt_st.pins.head_move_oe = st_ff.pulse_cnt != 7'h00;
    nxt_st.pins.rate_band = (st_ff.rate == RATE_500)
                            || (st_ff.rate == RATE_1M);
    nxt_st.pins.separator_lock_sel = st_ff.mode[MODE_RG_BIT]
                                     ? st_ff.filt[B_CHG] : 1'b1;
    nxt_st.pins.dma_request = st_ff.dctl[DCTL_DMA_BIT] && wr_mode
                              && !st_ff.wfull && !grant_act;
    nxt_st.pins.disk_interrupt = st_ff.dctl[DCTL_DMA_BIT]
                                 && st_ff.int_pend;

    // Master clear restores all drive-facing state
    if (st_ff.filt[B_MC]) begin
      nxt_st.config_r   = CONFIG_RST;
      nxt_st.mode       = MODE_RST;
      nxt_st.dctl       = DCTL_RST;
      nxt_st.rate       = RATE_RST;
      nxt_st.op         = 3'h0;
      nxt_st.wfull      = 1'b0;
      nxt_st.bitcnt     = 4'h0;
      nxt_st.seeking    = 1'b0;
      nxt_st.dir_in     = 1'b0;
      nxt_st.steps_left = 7'h00;
      nxt_st.period_cnt = 21'h000000;
      nxt_st.pulse_cnt  = 7'h00;
      nxt_st.int_pend   = 1'b0;
      nxt_st.rd_pulses  = 8'h00;
      nxt_st.pins       = OUT_RST;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff            <= '0;
      st_ff.sync1      <= IN_RST;
      st_ff.sync2      <= IN_RST;
      st_ff.sync3      <= IN_RST;
      st_ff.filt       <= IN_RST;
      st_ff.filt_q     <= IN_RST;
      st_ff.config_r   <= CONFIG_RST;
      st_ff.mode       <= MODE_RST;
      st_ff.dctl       <= DCTL_RST;
      st_ff.rate       <= RATE_RST;
      st_ff.pins       <= OUT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule
`default_nettype wire

// [tb/fdd_assertions.sv]
// Purpose: Port-level property checks for the disk interface
// Assumes: One clock; resetn asynchronous, active low
// Notes:   Seven cycles cover the input filter latency
`timescale 1ns/1ps
`default_nettype none
module fdd_checker
  import fdd_pkg::*;
#(
  parameter int STEP_UNIT = STEP_UNIT_CYC
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire drv_in_s     drv_in,
  input wire drv_out_s    drv_out
);
  logic [6:0] mv_cnt_ff;
  logic [6:0] nxt_mv_cnt;

  // Length of the current step pulse
  always_comb nxt_mv_cnt = drv_out.head_move_oe ? mv_cnt_ff + 7'h1 : 7'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mv_cnt_ff <= 7'h0;
    end else begin
      mv_cnt_ff <= nxt_mv_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack lasted more than one cycle");
  chk_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Request not answered next cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("Read data outside ack");
  chk_one_unit: assert property (!(&drv_out.unit_select_n_oe))
    else $error("Both units selected");
  chk_grant_drop: assert property (
      !drv_in.dma_grant_n [*7] |-> !drv_out.dma_request)
    else $error("Request kept under grant");
  chk_clear_outs: assert property (
      drv_in.master_clear [*7] |-> (drv_out & 13'h1ffb) == 13'h0)
    else $error("Outputs active under master clear");
  chk_gate_data: assert property (
      drv_out.disk_write_data_oe |-> drv_out.disk_write_enable_oe)
    else $error("Write pulse without write gate");
  chk_travel_write: assert property (
      drv_out.disk_write_data_oe |-> !drv_out.head_travel_oe)
    else $error("Direction pulled low while writing");
  chk_travel_hold: assert property (
      drv_out.head_move_oe && $past(drv_out.head_move_oe)
      |-> $stable(drv_out.head_travel_oe))
    else $error("Direction moved inside a step");
  chk_step_width: assert property (
      $fell(drv_out.head_move_oe) |-> mv_cnt_ff == STEP_PULSE_CYC)
    else $error("Step pulse width wrong");

  cover property ($rose(drv_out.head_move_oe));
  cover property ($rose(drv_out.disk_write_data_oe));
  cover property ($rose(drv_out.disk_interrupt));
endmodule

bind flexible_disk_drive_interface fdd_checker #(.STEP_UNIT(STEP_UNIT)) u_chk (
  .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .drv_in(drv_in), .drv_out(drv_out));
`default_nettype wire

// [tb/disk_drive_model.sv]
// Purpose: Behavioural flexible-disk drive on the far side of the pins
// Assumes: Head starts on the home track
// Notes:   Released inputs rest at their pull-up level
`timescale 1ns/1ps
`default_nettype none
module disk_drive_model
  import fdd_pkg::*;
(
  input wire logic     clk,
  input wire logic     resetn,
  input wire drv_out_s drv_out,
  input wire logic     rd_en,
  output logic         home_track_n,
  output logic         track_start_n,
  output logic         disk_read_n
);
  int         pos_ff;
  logic       mv_ff;
  logic [8:0] rot_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_ff <= 0;
      mv_ff <= 1'h0;
      rot_ff <= 9'h0;
    end else begin
      mv_ff <= drv_out.head_move_oe;
      rot_ff <= rot_ff + 9'h1;
      // Head moves on the leading edge of each step
      if (drv_out.head_move_oe && !mv_ff) begin
        if (drv_out.head_travel_oe) begin
          pos_ff <= pos_ff + 1;
        end else if (pos_ff > 0) begin
          pos_ff <= pos_ff - 1;
        end
      end
    end
  end

  assign home_track_n = (pos_ff != 0);
  assign track_start_n = !(rot_ff < 9'h4 && |drv_out.spindle_on_n_oe);
  assign disk_read_n = !(rd_en && rot_ff[5:0] < 6'h2);
endmodule
`default_nettype wire

// [tb/flexible_disk_drive_interface_tb.sv]
// Purpose: Self-checking bench for the disk drive interface
// Assumes: Step unit shortened to 20 cycles
// Notes:   Drive inputs pass a filter, so input changes wait 8 cycles
`timescale 1ns/1ps
`default_nettype none
module flexible_disk_drive_interface_tb
  import fdd_pkg::*;
;
  logic        clk, ack, trk_n, idx_n, rd_n, mv_q, wd_q;
  logic        resetn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic        mc = 1'h0, aen = 1'h0, chg = 1'h0, te = 1'h0, rd_en = 1'h0;
  logic        lock_n = 1'h1, gnt_n = 1'h1;
  logic [5:0]  adr = 6'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic [7:0]  v;
  logic [3:0]  sp;
  logic [3:0]  sel = 4'h1;
  drv_out_s    dout;
  int          mismatches = 0, n_compared = 0, n_mv = 0, n_wd = 0;

  flexible_disk_drive_interface #(.STEP_UNIT(20)) uut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .drv_out(dout),
    .drv_in({mc, aen, rd_n, idx_n, trk_n, lock_n, chg, te, gnt_n}));
  disk_drive_model drive (.clk(clk), .resetn(resetn), .drv_out(dout),
    .rd_en(rd_en), .home_track_n(trk_n), .track_start_n(idx_n),
    .disk_read_n(rd_n));
  assign sp = {dout.unit_select_n_oe, dout.spindle_on_n_oe};

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Count leading edges of step and write pulses
  always @(posedge clk) begin
    mv_q <= dout.head_move_oe;
    wd_q <= dout.disk_write_data_oe;
    if (dout.head_move_oe && !mv_q) n_mv++;
    if (dout.disk_write_data_oe && !wd_q) n_wd++;
  end

  task automatic chk(input logic [31:0] a, input logic [31:0] b);
    n_compared++;
    if (a !== b) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, a, b);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic [3:0] s, input logic r, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= r;
    adr <= {s, 2'h0};
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'h1);
    v = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    bus(s, 1'h1, d);
    w(3);
  endtask
  task automatic rd(input logic [3:0] s);
    bus(s, 1'h0, 8'h0);
  endtask

  task t_reset;
    rd(IDX_MSR); chk(v, MSR_BASE);
    rd(4'h9); chk(v, 8'h0);
    sel <= 4'h0;
    wr(IDX_CONFIG, 8'h80);
    sel <= 4'h1;
    rd(IDX_CONFIG); chk(v, CONFIG_RST);
    chk(dout.rate_band, 1'h0);
  endtask
  task t_sel;
    wr(IDX_DCTL, 8'h10); chk(sp, 4'h5);
    wr(IDX_DCTL, 8'h01); chk(sp, 4'h0);
    wr(IDX_DCTL, 8'h21); chk(sp, 4'ha);
    wr(IDX_CONFIG, 8'h80); chk(sp, 4'hb);
    wr(IDX_CONFIG, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_RATE, 8'(r));
      chk(dout.rate_band, r == 0 || r == 3);
    end
    wr(IDX_OP, 8'h01); chk(dout.head_choice_oe, 1'h1);
    wr(IDX_OP, 8'h00); chk(dout.head_choice_oe, 1'h0);
  endtask
  task t_seek;
    wr(IDX_MODE, 8'h09);
    wr(IDX_DCTL, 8'h10);
    n_mv = 0;
    wr(IDX_SEEK, 8'h83);
    w(50); chk(dout.head_travel_oe, 1'h1);
    w(800); chk(n_mv, 3);
    chk(dout.disk_interrupt, 1'h0);
    wr(IDX_DCTL, 8'h18); chk(dout.disk_interrupt, 1'h1);
    rd(IDX_MSR); w(3); chk(dout.disk_interrupt, 1'h0);
    n_mv = 0;
    wr(IDX_SEEK, 8'h0a);
    w(50); chk(dout.head_travel_oe, 1'h0);
    w(1200); chk(n_mv, 3);
  endtask
  task t_write;
    // Seek completion left an interrupt pending; clear it first
    rd(IDX_MSR);
    wr(IDX_RATE, 8'h03);
    wr(IDX_DCTL, 8'h10);
    wr(IDX_OP, 8'h04); chk(dout.dma_request, 1'h0);
    chk(dout.disk_write_enable_oe, 1'h1);
    wr(IDX_DCTL, 8'h18); chk(dout.dma_request, 1'h1);
    gnt_n <= 1'h0; w(8); chk(dout.dma_request, 1'h0);
    gnt_n <= 1'h1;
    n_wd = 0;
    wr(IDX_DATA, 8'ha5); w(900); chk(n_wd, 4);
    te <= 1'h1; w(8); te <= 1'h0; w(8);
    chk(dout.disk_interrupt, 1'h0);
    gnt_n <= 1'h0; te <= 1'h1; w(8); te <= 1'h0; gnt_n <= 1'h1; w(8);
    chk(dout.disk_interrupt, 1'h1);
    chk(dout.disk_write_enable_oe, 1'h0);
    rd(IDX_MSR);
    lock_n <= 1'h0; w(8);
    wr(IDX_OP, 8'h04);
    n_wd = 0;
    wr(IDX_DATA, 8'hff); w(900); chk(n_wd, 0);
    wr(IDX_OP, 8'h00);
    lock_n <= 1'h1;
  endtask
  task t_misc;
    wr(IDX_SEEK, 8'h81); w(300);
    wr(IDX_OP, 8'h02); chk(dout.head_travel_oe, 1'h0);
    rd_en <= 1'h1; w(600); rd(IDX_DATA); chk(v != 8'h0, 1'h1);
    rd_en <= 1'h0;
    wr(IDX_OP, 8'h00);
    chg <= 1'h1; w(8); rd(IDX_DIN); chk(v[7], 1'h1);
    wr(IDX_MODE, 8'h89); chk(dout.separator_lock_sel, 1'h1);
    chg <= 1'h0; w(8); chk(dout.separator_lock_sel, 1'h0);
    wr(IDX_MODE, 8'h09);
    aen <= 1'h1; w(8); wr(IDX_DCTL, 8'h30);
    rd(IDX_MSR); chk(v, 8'h0);
    aen <= 1'h0; w(8); rd(IDX_DCTL); chk(v, 8'h18);
    wr(IDX_RATE, 8'h00);
    mc <= 1'h1; w(8); chk(sp, 4'h0);
    mc <= 1'h0; w(8); rd(IDX_DCTL); chk(v, DCTL_RST);
    rd(IDX_RATE); chk(v[1:0], RATE_RST);
  endtask

  task close_out;
    $display("mismatches %0d, compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    t_reset;
    t_sel;
    t_seek;
    t_write;
    t_misc;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
